// [design/xsod_decoder.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - word memory add, carry, borrow and sign-flip forms add four clocks
// - memory accesses may need two extra clocks
// - 8e copies into segment, 2/13 clocks
// - 8c copies segment out, 2/15 clocks
// - d7 table lookup byte, 15 clocks
// - 8d effective address load, 6 clocks
// - c5/c4 pointer loads, 26 clocks, memory only
// - 9f flags to high byte 2, 9e 3
// - four segment prefixes, 2 clocks each
// - add decodes, 3/10 and 4/16 clocks
// - add with carry decodes, accumulator 3/4
// - difference with borrow decodes
// - sign flip, 3/10 clocks
// - ascii sum 8, ascii difference 7 clocks
// - bcd fixups, 4 clocks each
// - unsigned product clocks by size and form
// - signed product clocks by size and form
// - immediate signed product, 22-25/29-32 clocks
// - unsigned quotient 29/38/35/44 clocks
// - signed quotient ranges 44-67 clocks
// - ascii product 19, quotient prep 15
// - sign extends, 2 and 4 clocks
// - form 11 names a register operand
// - form 01 sign-extends single displacement byte
// - address time is inside listed counts
module xsod_decoder (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] modrm_in,
  input wire logic [7:0] disp_lo_in,
  input wire logic [7:0] disp_hi_in,
  output logic ready_out,
  output logic done_out,
  output logic [4:0] op_class_out,
  output logic [6:0] min_clocks_out,
  output logic [6:0] max_clocks_out,
  output logic mem_operand_out,
  output logic word_op_out,
  output logic [1:0] seg_select_out,
  output logic seg_override_out,
  output logic [15:0] disp_out,
  output logic [2:0] reg_field_out,
  output logic [2:0] rm_field_out,
  output logic unknown_out,
  output logic invalid_operand_out
);
  // register-or-memory pair selector
  function automatic logic [6:0] pick(input logic mem, input logic [6:0] r,
                                      input logic [6:0] m);
    pick = mem ? m : r;
  endfunction : pick

  // four-way count for multiply and divide groups
  function automatic logic [6:0] md_base(input logic [6:0] base, input logic w,
                                         input logic mem);
    logic [6:0] v;
    v = base;
    if (w) begin
      v = v + xsod_pkg::CLK_WORD_STEP;
    end
    if (mem) begin
      v = v + xsod_pkg::CLK_MEM_STEP;
    end
    md_base = v;
  endfunction : md_base

  xsod_pkg::xsod_op_type op;
  logic [6:0] cmin;
  logic [6:0] span;
  logic mem;
  logic word;
  logic unk;
  logic bad;
  logic [2:0] sub;
  logic has_modrm;
  logic [15:0] disp;
  logic [1:0] seg_sel;
  logic seg_ovr;
  logic timer_busy;
  logic timer_done;
  logic start;

  logic [4:0] class_ff;
  logic [4:0] nxt_class;
  logic [6:0] min_ff;
  logic [6:0] nxt_min;
  logic [6:0] max_ff;
  logic [6:0] nxt_max;
  logic mem_ff;
  logic nxt_mem;
  logic word_ff;
  logic nxt_word;
  logic [1:0] seg_ff;
  logic [1:0] nxt_seg;
  logic ovr_ff;
  logic nxt_ovr;
  logic [15:0] disp_ff;
  logic [15:0] nxt_disp;
  logic [2:0] reg_ff;
  logic [2:0] nxt_reg;
  logic [2:0] rm_ff;
  logic [2:0] nxt_rm;
  logic unk_ff;
  logic nxt_unk;
  logic bad_ff;
  logic nxt_bad;

  assign sub = modrm_in[5:3];
  assign mem = (modrm_in[7:6] != xsod_pkg::MOD_REG);

  // opcode decode and minimum clock table; address time already in figures
  always_comb begin
    op = xsod_pkg::XSOD_OP_NONE;
    cmin = xsod_pkg::CLK_2;
    span = '0;
    word = opcode_in[0];
    unk = 1'b0;
    bad = 1'b0;
    has_modrm = 1'b1;
    seg_sel = 2'h0;
    seg_ovr = 1'b0;
    case (opcode_in)
      xsod_pkg::OPC_TO_SEG: begin
        op = xsod_pkg::XSOD_OP_COPY_TO_SEG;
        cmin = pick(mem, xsod_pkg::CLK_2, xsod_pkg::CLK_13);
        unk = modrm_in[5]; // zero bit must be clear
        word = 1'b1;
      end
      xsod_pkg::OPC_FROM_SEG: begin
        op = xsod_pkg::XSOD_OP_COPY_FROM_SEG;
        cmin = pick(mem, xsod_pkg::CLK_2, xsod_pkg::CLK_15);
        unk = modrm_in[5];
        word = 1'b1;
      end
      xsod_pkg::OPC_LOOKUP: begin
        op = xsod_pkg::XSOD_OP_TABLE_LOOKUP;
        cmin = xsod_pkg::CLK_15;
        has_modrm = 1'b0;
        word = 1'b0;
      end
      xsod_pkg::OPC_EA_LOAD: begin
        op = xsod_pkg::XSOD_OP_EA_LOAD;
        cmin = xsod_pkg::CLK_6;
        word = 1'b1;
      end
      xsod_pkg::OPC_PTR_DS, xsod_pkg::OPC_PTR_ES: begin
        op = opcode_in[0] ? xsod_pkg::XSOD_OP_PTR_LOAD_DS : xsod_pkg::XSOD_OP_PTR_LOAD_ES;
        cmin = xsod_pkg::CLK_26;
        word = 1'b1;
        bad = (modrm_in[7:6] == xsod_pkg::MOD_REG);
      end
      xsod_pkg::OPC_FLAGS_HI: begin
        op = xsod_pkg::XSOD_OP_FLAGS_TO_HI;
        cmin = xsod_pkg::CLK_2;
        has_modrm = 1'b0;
      end
      xsod_pkg::OPC_HI_FLAGS: begin
        op = xsod_pkg::XSOD_OP_HI_TO_FLAGS;
        cmin = xsod_pkg::CLK_3;
        has_modrm = 1'b0;
      end
      xsod_pkg::OPC_SEG_CS, xsod_pkg::OPC_SEG_SS, xsod_pkg::OPC_SEG_DS,
      xsod_pkg::OPC_SEG_ES: begin
        op = xsod_pkg::XSOD_OP_SEG_PREFIX;
        cmin = xsod_pkg::CLK_2;
        has_modrm = 1'b0;
        seg_sel = opcode_in[4:3]; // 00 extra, 01 code, 10 stack, 11 data
        seg_ovr = 1'b1;
      end
      xsod_pkg::OPC_ASCII_SUM: begin
        op = xsod_pkg::XSOD_OP_ASCII_SUM;
        cmin = xsod_pkg::CLK_8;
        has_modrm = 1'b0;
      end
      xsod_pkg::OPC_ASCII_DIFF: begin
        op = xsod_pkg::XSOD_OP_ASCII_DIFF;
        cmin = xsod_pkg::CLK_7;
        has_modrm = 1'b0;
      end
      xsod_pkg::OPC_BCD_SUM, xsod_pkg::OPC_BCD_DIFF: begin
        op = opcode_in[3] ? xsod_pkg::XSOD_OP_BCD_DIFF : xsod_pkg::XSOD_OP_BCD_SUM;
        cmin = xsod_pkg::CLK_4;
        has_modrm = 1'b0;
      end
      xsod_pkg::OPC_AJ_PROD, xsod_pkg::OPC_AJ_QUOT: begin
        op = opcode_in[0] ? xsod_pkg::XSOD_OP_ASCII_QUOT_PREP
                          : xsod_pkg::XSOD_OP_ASCII_PRODUCT;
        cmin = opcode_in[0] ? xsod_pkg::CLK_15 : xsod_pkg::CLK_19;
        has_modrm = 1'b0;
        unk = (modrm_in != xsod_pkg::AJ_BASE); // second byte must be 0a
      end
      xsod_pkg::OPC_B2W, xsod_pkg::OPC_W2L: begin
        op = opcode_in[0] ? xsod_pkg::XSOD_OP_WORD_TO_LONG
                          : xsod_pkg::XSOD_OP_BYTE_TO_WORD;
        cmin = opcode_in[0] ? xsod_pkg::CLK_4 : xsod_pkg::CLK_2;
        has_modrm = 1'b0;
      end
      default: begin
        if (opcode_in[7:2] == xsod_pkg::GRP_IMM) begin
          cmin = pick(mem, xsod_pkg::CLK_4, xsod_pkg::CLK_16);
          case (sub)
            xsod_pkg::SUB_ADD: op = xsod_pkg::XSOD_OP_ADD;
            xsod_pkg::SUB_ADD_CARRY: op = xsod_pkg::XSOD_OP_ADD_CARRY;
            xsod_pkg::SUB_DIFF_BORROW: op = xsod_pkg::XSOD_OP_DIFF_BORROW;
            default: unk = 1'b1;
          endcase
        end else if (opcode_in[7:2] == xsod_pkg::RM_ADD ||
                     opcode_in[7:2] == xsod_pkg::RM_ADD_CARRY ||
                     opcode_in[7:2] == xsod_pkg::RM_DIFF_BORROW) begin
          op = (opcode_in[4:3] == 2'h0) ? xsod_pkg::XSOD_OP_ADD
             : (opcode_in[4:3] == 2'h2) ? xsod_pkg::XSOD_OP_ADD_CARRY
             : xsod_pkg::XSOD_OP_DIFF_BORROW;
          cmin = pick(mem, xsod_pkg::CLK_3, xsod_pkg::CLK_10);
        end else if (opcode_in[7:1] == xsod_pkg::ACC_ADD ||
                     opcode_in[7:1] == xsod_pkg::ACC_ADD_CARRY ||
                     opcode_in[7:1] == xsod_pkg::ACC_DIFF_BORROW) begin
          op = (opcode_in[4:3] == 2'h0) ? xsod_pkg::XSOD_OP_ADD
             : (opcode_in[4:3] == 2'h2) ? xsod_pkg::XSOD_OP_ADD_CARRY
             : xsod_pkg::XSOD_OP_DIFF_BORROW;
          has_modrm = 1'b0;
          cmin = word ? xsod_pkg::CLK_4 : xsod_pkg::CLK_3;
        end else if (opcode_in[7:1] == xsod_pkg::GRP_UNARY) begin
          case (sub)
            xsod_pkg::SUB_FLIP: begin
              op = xsod_pkg::XSOD_OP_SIGN_FLIP;
              cmin = pick(mem, xsod_pkg::CLK_3, xsod_pkg::CLK_10);
            end
            xsod_pkg::SUB_UMUL: begin
              op = xsod_pkg::XSOD_OP_UPRODUCT;
              cmin = md_base(xsod_pkg::CLK_UMUL_MIN, word, mem);
              span = xsod_pkg::SPAN_MUL;
            end
            xsod_pkg::SUB_SMUL: begin
              op = xsod_pkg::XSOD_OP_SPRODUCT;
              cmin = md_base(xsod_pkg::CLK_SMUL_MIN, word, mem);
              span = xsod_pkg::SPAN_SMUL;
            end
            xsod_pkg::SUB_UDIV: begin
              op = xsod_pkg::XSOD_OP_UQUOTIENT;
              cmin = md_base(xsod_pkg::CLK_UDIV_MIN, word, mem);
            end
            xsod_pkg::SUB_SDIV: begin
              op = xsod_pkg::XSOD_OP_SQUOTIENT;
              cmin = md_base(xsod_pkg::CLK_SDIV_MIN, word, mem);
              span = xsod_pkg::SPAN_SDIV;
            end
            default: unk = 1'b1;
          endcase
        end else if (opcode_in[7:2] == xsod_pkg::IMM_MUL && opcode_in[0]) begin
          op = xsod_pkg::XSOD_OP_SPRODUCT_IMM;
          word = 1'b1; // s only narrows the immediate
          cmin = pick(mem, xsod_pkg::CLK_SIGNED_PRODUCT_OP_IMM_MIN,
                      xsod_pkg::CLK_SIGNED_PRODUCT_OP_IMM_MEM_MIN);
          span = xsod_pkg::SPAN_SMUL;
        end else begin
          unk = 1'b1;
          has_modrm = 1'b0;
        end
      end
    endcase
    // word add, carry, borrow and sign-flip forms touching memory pay four more
    if (mem && word && (opcode_in[7:2] == xsod_pkg::GRP_IMM ||
        opcode_in[7:2] == xsod_pkg::RM_ADD || opcode_in[7:2] == xsod_pkg::RM_ADD_CARRY ||
        opcode_in[7:2] == xsod_pkg::RM_DIFF_BORROW ||
        (opcode_in[7:1] == xsod_pkg::GRP_UNARY && sub == xsod_pkg::SUB_FLIP))) begin
      cmin = cmin + xsod_pkg::CLK_WORD_MEM_EXTRA;
    end
  end

  // displacement: 01 sign-extends one byte, 10 and direct take two
  always_comb begin
    disp = 16'h0000;
    if (has_modrm) begin
      case (modrm_in[7:6])
        xsod_pkg::MOD_DISP8: disp = {{8{disp_lo_in[7]}}, disp_lo_in};
        xsod_pkg::MOD_DISP16: disp = {disp_hi_in, disp_lo_in};
        xsod_pkg::MOD_NO_DISP: begin
          if (modrm_in[2:0] == xsod_pkg::RM_DIRECT) begin
            disp = {disp_hi_in, disp_lo_in};
          end
        end
        default: disp = 16'h0000;
      endcase
    end
  end

  xsod_timer #(.CW(7)) u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(start),
    .count_in(cmin),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // accept only when idle; timer holds off the prefetch queue
  assign ready_out = !timer_busy;
  assign start = valid_in && !timer_busy && !unk && !bad;

  // latched results of the last accepted or rejected instruction
  always_comb begin
    nxt_class = class_ff;
    nxt_min = min_ff;
    nxt_max = max_ff;
    nxt_mem = mem_ff;
    nxt_word = word_ff;
    nxt_seg = seg_ff;
    nxt_ovr = ovr_ff;
    nxt_disp = disp_ff;
    nxt_reg = reg_ff;
    nxt_rm = rm_ff;
    nxt_unk = unk_ff;
    nxt_bad = bad_ff;
    if (valid_in && !timer_busy) begin
      nxt_class = op;
      nxt_min = cmin;
      // memory forms may stretch by the handshake slack
      nxt_max = cmin + span
        + ((mem && has_modrm) ? {5'h00, xsod_pkg::CLK_HANDSHAKE_MAX} : 7'h00);
      nxt_mem = mem && has_modrm;
      nxt_word = word;
      nxt_seg = seg_sel;
      nxt_ovr = seg_ovr;
      nxt_disp = disp;
      nxt_reg = modrm_in[5:3];
      nxt_rm = modrm_in[2:0];
      nxt_unk = unk;
      nxt_bad = bad;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      class_ff <= 5'h00;
      min_ff <= 7'h00;
      max_ff <= 7'h00;
      mem_ff <= 1'b0;
      word_ff <= 1'b0;
      seg_ff <= 2'h0;
      ovr_ff <= 1'b0;
      disp_ff <= 16'h0000;
      reg_ff <= 3'h0;
      rm_ff <= 3'h0;
      unk_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else begin
      class_ff <= nxt_class;
      min_ff <= nxt_min;
      max_ff <= nxt_max;
      mem_ff <= nxt_mem;
      word_ff <= nxt_word;
      seg_ff <= nxt_seg;
      ovr_ff <= nxt_ovr;
      disp_ff <= nxt_disp;
      reg_ff <= nxt_reg;
      rm_ff <= nxt_rm;
      unk_ff <= nxt_unk;
      bad_ff <= nxt_bad;
    end
  end

  assign done_out = timer_done;
  assign op_class_out = class_ff;
  assign min_clocks_out = min_ff;
  assign max_clocks_out = max_ff;
  assign mem_operand_out = mem_ff;
  assign word_op_out = word_ff;
  assign seg_select_out = seg_ff;
  assign seg_override_out = ovr_ff;
  assign disp_out = disp_ff;
  assign reg_field_out = reg_ff;
  assign rm_field_out = rm_ff;
  assign unknown_out = unk_ff;
  assign invalid_operand_out = bad_ff;
endmodule : xsod_decoder

// [design/xsod_pkg.sv]
package xsod_pkg;
  // decoded operation classes
  typedef enum logic [4:0] {
    XSOD_OP_NONE, XSOD_OP_COPY_TO_SEG, XSOD_OP_COPY_FROM_SEG, XSOD_OP_TABLE_LOOKUP,
    XSOD_OP_EA_LOAD, XSOD_OP_PTR_LOAD_DS, XSOD_OP_PTR_LOAD_ES, XSOD_OP_FLAGS_TO_HI,
    XSOD_OP_HI_TO_FLAGS, XSOD_OP_SEG_PREFIX, XSOD_OP_ADD, XSOD_OP_ADD_CARRY,
    XSOD_OP_DIFF_BORROW, XSOD_OP_SIGN_FLIP, XSOD_OP_ASCII_SUM, XSOD_OP_ASCII_DIFF,
    XSOD_OP_BCD_SUM, XSOD_OP_BCD_DIFF, XSOD_OP_UPRODUCT, XSOD_OP_SPRODUCT,
    XSOD_OP_SPRODUCT_IMM, XSOD_OP_UQUOTIENT, XSOD_OP_SQUOTIENT, XSOD_OP_ASCII_PRODUCT,
    XSOD_OP_ASCII_QUOT_PREP, XSOD_OP_BYTE_TO_WORD, XSOD_OP_WORD_TO_LONG
  } xsod_op_type;

  // operand form field values
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [7:0] AJ_BASE = 8'h0a;

  // opcode bytes
  localparam logic [7:0] OPC_TO_SEG = 8'h8e;
  localparam logic [7:0] OPC_FROM_SEG = 8'h8c;
  localparam logic [7:0] OPC_LOOKUP = 8'hd7;
  localparam logic [7:0] OPC_EA_LOAD = 8'h8d;
  localparam logic [7:0] OPC_PTR_DS = 8'hc5;
  localparam logic [7:0] OPC_PTR_ES = 8'hc4;
  localparam logic [7:0] OPC_FLAGS_HI = 8'h9f;
  localparam logic [7:0] OPC_HI_FLAGS = 8'h9e;
  localparam logic [7:0] OPC_SEG_CS = 8'h2e;
  localparam logic [7:0] OPC_SEG_SS = 8'h36;
  localparam logic [7:0] OPC_SEG_DS = 8'h3e;
  localparam logic [7:0] OPC_SEG_ES = 8'h26;
  localparam logic [7:0] OPC_ASCII_SUM = 8'h37;
  localparam logic [7:0] OPC_ASCII_DIFF = 8'h3f;
  localparam logic [7:0] OPC_BCD_SUM = 8'h27;
  localparam logic [7:0] OPC_BCD_DIFF = 8'h2f;
  localparam logic [7:0] OPC_AJ_PROD = 8'hd4;
  localparam logic [7:0] OPC_AJ_QUOT = 8'hd5;
  localparam logic [7:0] OPC_B2W = 8'h98;
  localparam logic [7:0] OPC_W2L = 8'h99;
  // masked group patterns (top bits)
  localparam logic [5:0] GRP_IMM = 6'h20;      // 100000sw
  localparam logic [6:0] GRP_UNARY = 7'h7b;    // 1111011w
  localparam logic [6:0] ACC_ADD = 7'h02;      // 0000010w
  localparam logic [5:0] RM_ADD_CARRY = 6'h04; // 000100dw
  localparam logic [6:0] ACC_ADD_CARRY = 7'h0a;
  localparam logic [5:0] RM_DIFF_BORROW = 6'h06;
  localparam logic [6:0] ACC_DIFF_BORROW = 7'h0e;
  localparam logic [5:0] RM_ADD = 6'h00;       // 000000dw
  localparam logic [5:0] IMM_MUL = 6'h1a;      // 011010s1 with low bit 1
  // sub-op values
  localparam logic [2:0] SUB_ADD = 3'h0;
  localparam logic [2:0] SUB_ADD_CARRY = 3'h2;
  localparam logic [2:0] SUB_DIFF_BORROW = 3'h3;
  localparam logic [2:0] SUB_FLIP = 3'h3;
  localparam logic [2:0] SUB_UMUL = 3'h4;
  localparam logic [2:0] SUB_SMUL = 3'h5;
  localparam logic [2:0] SUB_UDIV = 3'h6;
  localparam logic [2:0] SUB_SDIV = 3'h7;

  // timing counts in clocks
  localparam logic [6:0] CLK_WORD_MEM_EXTRA = 7'h04;
  localparam logic [1:0] CLK_HANDSHAKE_MAX = 2'h2;
  localparam logic [6:0] CLK_EA_CALC = 7'h04;
  localparam logic [6:0] CLK_2 = 7'd2;
  localparam logic [6:0] CLK_3 = 7'd3;
  localparam logic [6:0] CLK_4 = 7'd4;
  localparam logic [6:0] CLK_6 = 7'd6;
  localparam logic [6:0] CLK_7 = 7'd7;
  localparam logic [6:0] CLK_8 = 7'd8;
  localparam logic [6:0] CLK_10 = 7'd10;
  localparam logic [6:0] CLK_13 = 7'd13;
  localparam logic [6:0] CLK_15 = 7'd15;
  localparam logic [6:0] CLK_16 = 7'd16;
  localparam logic [6:0] CLK_19 = 7'd19;
  localparam logic [6:0] CLK_26 = 7'd26;
  localparam logic [6:0] CLK_UMUL_MIN = 7'd26; // reg byte; +9 word, +6 mem
  localparam logic [6:0] CLK_SMUL_MIN = 7'd25;
  localparam logic [6:0] CLK_UDIV_MIN = 7'd29;
  localparam logic [6:0] CLK_SDIV_MIN = 7'd44;
  localparam logic [6:0] CLK_SIGNED_PRODUCT_OP_IMM_MIN = 7'd22;
  localparam logic [6:0] CLK_SIGNED_PRODUCT_OP_IMM_MEM_MIN = 7'd29;
  localparam logic [6:0] CLK_WORD_STEP = 7'd9;
  localparam logic [6:0] CLK_MEM_STEP = 7'd6;
  localparam logic [6:0] SPAN_MUL = 7'd2;
  localparam logic [6:0] SPAN_SMUL = 7'd3;
  localparam logic [6:0] SPAN_SDIV = 7'd8;
endpackage : xsod_pkg

// [design/xsod_timer.sv]
`timescale 1ns/1ps
// counts the execution clocks of one decoded instruction
module xsod_timer #(
  parameter int CW = 7
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [CW-1:0] count_in,
  output logic busy_out,
  output logic done_out
);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // load on start, count to one, then pulse done
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (start_in) begin
      nxt_cnt = count_in - 1'b1;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == {{(CW-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy_out = (cnt_ff != '0);
  assign done_out = done_ff;
endmodule : xsod_timer

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clock_in, rst_in, load, valid, taken, ready, done, mem, word, ovr, unk, bad;
  logic [31:0] bytes, q_bytes;
  logic [4:0] cls;
  logic [6:0] minc, maxc;
  logic [1:0] seg;
  logic [15:0] disp;
  logic [2:0] regf, rmf;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  xsod_queue_model u_queue (.clock_in(clock_in), .rst_in(rst_in), .ready_in(ready),
    .load_in(load), .bytes_in(bytes), .valid_out(valid), .taken_out(taken),
    .bytes_out(q_bytes));
  xsod_decoder u_dut (.clock_in(clock_in), .rst_in(rst_in), .valid_in(valid),
    .opcode_in(q_bytes[31:24]), .modrm_in(q_bytes[23:16]), .disp_lo_in(q_bytes[15:8]),
    .disp_hi_in(q_bytes[7:0]), .ready_out(ready), .done_out(done), .op_class_out(cls),
    .min_clocks_out(minc), .max_clocks_out(maxc), .mem_operand_out(mem), .word_op_out(word),
    .seg_select_out(seg), .seg_override_out(ovr), .disp_out(disp), .reg_field_out(regf),
    .rm_field_out(rmf), .unknown_out(unk), .invalid_operand_out(bad));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // hang guard, far above what the run needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // queue one instruction; returns in the first cycle after the take
  task issue(input logic [31:0] b);
    int n;
    @(posedge clock_in); #1;
    load = 1'b1;
    bytes = b;
    @(posedge clock_in); #1;
    load = 1'b0;
    n = 0;
    while (taken !== 1'b1 && n < 200) begin
      @(posedge clock_in); #1;
      n++;
    end
  endtask : issue
  // 7f as max skips the upper figure where memory use is unclear
  task run(input logic [31:0] b, input xsod_pkg::xsod_op_type c, input logic [6:0] mn,
           input logic [6:0] mx);
    int n;
    issue(b);
    check(cls, c, "class");
    check(minc, mn, "min count");
    if (mx != 7'h7f) check(maxc, mx, "max count");
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clock_in); #1;
      n++;
    end
    check(16'(n), mn, "done cycle");
  endtask : run
  task t_transfer;
    run(32'h8ed80000, xsod_pkg::XSOD_OP_COPY_TO_SEG, 7'd2, 7'd2);
    run(32'h8e1f0000, xsod_pkg::XSOD_OP_COPY_TO_SEG, 7'd13, 7'd15);
    run(32'h8c470500, xsod_pkg::XSOD_OP_COPY_FROM_SEG, 7'd15, 7'd17);
    run(32'hd7000000, xsod_pkg::XSOD_OP_TABLE_LOOKUP, 7'd15, 7'h7f);
    run(32'h9f000000, xsod_pkg::XSOD_OP_FLAGS_TO_HI, 7'd2, 7'd2);
    run(32'h9e000000, xsod_pkg::XSOD_OP_HI_TO_FLAGS, 7'd3, 7'd3);
  endtask : t_transfer
  task t_prefix;
    for (int p = 0; p < 4; p++) begin
      run({3'h1, 2'(p), 27'h6000000}, xsod_pkg::XSOD_OP_SEG_PREFIX, 7'd2, 7'd2);
      check({14'h0000, seg}, 16'(p), "segment");
    end
  endtask : t_prefix
  task t_arith;
    run(32'h00c10000, xsod_pkg::XSOD_OP_ADD, 7'd3, 7'd3);
    run(32'h81061234, xsod_pkg::XSOD_OP_ADD, 7'd20, 7'd22);
    check({14'h0000, mem, word}, 16'h0003, "flags");
    run(32'h05000000, xsod_pkg::XSOD_OP_ADD, 7'd4, 7'd4);
    run(32'h11070000, xsod_pkg::XSOD_OP_ADD_CARRY, 7'd14, 7'd16);
    run(32'h80d00000, xsod_pkg::XSOD_OP_ADD_CARRY, 7'd4, 7'd4);
    run(32'h14000000, xsod_pkg::XSOD_OP_ADD_CARRY, 7'd3, 7'd3);
    run(32'h18c00000, xsod_pkg::XSOD_OP_DIFF_BORROW, 7'd3, 7'd3);
    run(32'h80d80000, xsod_pkg::XSOD_OP_DIFF_BORROW, 7'd4, 7'd4);
    run(32'h1d000000, xsod_pkg::XSOD_OP_DIFF_BORROW, 7'd4, 7'd4);
    run(32'hf6d80000, xsod_pkg::XSOD_OP_SIGN_FLIP, 7'd3, 7'd3);
    run(32'hf71f0000, xsod_pkg::XSOD_OP_SIGN_FLIP, 7'd14, 7'd16);
  endtask : t_arith
  task t_adjust;
    run(32'h37000000, xsod_pkg::XSOD_OP_ASCII_SUM, 7'd8, 7'd8);
    run(32'h3f000000, xsod_pkg::XSOD_OP_ASCII_DIFF, 7'd7, 7'd7);
    run(32'h27000000, xsod_pkg::XSOD_OP_BCD_SUM, 7'd4, 7'd4);
    run(32'h2f000000, xsod_pkg::XSOD_OP_BCD_DIFF, 7'd4, 7'd4);
    run(32'hd40a0000, xsod_pkg::XSOD_OP_ASCII_PRODUCT, 7'd19, 7'd19);
    run(32'hd50a0000, xsod_pkg::XSOD_OP_ASCII_QUOT_PREP, 7'd15, 7'd15);
    run(32'h98000000, xsod_pkg::XSOD_OP_BYTE_TO_WORD, 7'd2, 7'd2);
    run(32'h99000000, xsod_pkg::XSOD_OP_WORD_TO_LONG, 7'd4, 7'd4);
  endtask : t_adjust
  task t_muldiv;
    run(32'hf6e00000, xsod_pkg::XSOD_OP_UPRODUCT, 7'd26, 7'd28);
    run(32'hf7260000, xsod_pkg::XSOD_OP_UPRODUCT, 7'd41, 7'd45);
    run(32'hf7e80000, xsod_pkg::XSOD_OP_SPRODUCT, 7'd34, 7'd37);
    run(32'hf62e0000, xsod_pkg::XSOD_OP_SPRODUCT, 7'd31, 7'd36);
    run(32'h6bc00000, xsod_pkg::XSOD_OP_SPRODUCT_IMM, 7'd22, 7'd25);
    run(32'h69060000, xsod_pkg::XSOD_OP_SPRODUCT_IMM, 7'd29, 7'd34);
    run(32'hf7f00000, xsod_pkg::XSOD_OP_UQUOTIENT, 7'd38, 7'd38);
    run(32'hf6360000, xsod_pkg::XSOD_OP_UQUOTIENT, 7'd35, 7'd37);
    run(32'hf6f80000, xsod_pkg::XSOD_OP_SQUOTIENT, 7'd44, 7'd52);
    run(32'hf73e0000, xsod_pkg::XSOD_OP_SQUOTIENT, 7'd59, 7'd69);
  endtask : t_muldiv
  task t_disp;
    run(32'h8d458000, xsod_pkg::XSOD_OP_EA_LOAD, 7'd6, 7'h7f);
    check(disp, 16'hff80, "short disp");
    run(32'h8d863412, xsod_pkg::XSOD_OP_EA_LOAD, 7'd6, 7'h7f);
    check(disp, 16'h1234, "long disp");
    run(32'h8d0678a6, xsod_pkg::XSOD_OP_EA_LOAD, 7'd6, 7'h7f);
    check(disp, 16'ha678, "direct disp");
    run(32'h8ddd9abc, xsod_pkg::XSOD_OP_EA_LOAD, 7'd6, 7'h7f);
    check({10'h000, regf, rmf}, 16'h001d, "reg operand");
  endtask : t_disp
  // refused forms start no count; a reset mid-count clears everything
  task t_faults;
    run(32'hc4060000, xsod_pkg::XSOD_OP_PTR_LOAD_ES, 7'd26, 7'd28);
    run(32'hc5270000, xsod_pkg::XSOD_OP_PTR_LOAD_DS, 7'd26, 7'd28);
    issue(32'hf6c80000);
    check({15'h0000, unk}, 16'h0001, "unk op");
    issue(32'hc5c00000);
    check({14'h0000, unk, bad}, 16'h0001, "bad form");
    repeat (3) @(posedge clock_in);
    #1 check({15'h0000, ready}, 16'h0001, "idle after bad");
    issue(32'hf73e0000);
    repeat (5) @(posedge clock_in);
    #1 rst_in = 1'b1;
    #1 check({14'h0000, ready, done}, 16'h0002, "reset mid count");
    repeat (2) @(posedge clock_in);
    #1 rst_in = 1'b0;
    run(32'h9e000000, xsod_pkg::XSOD_OP_HI_TO_FLAGS, 7'd3, 7'd3);
  endtask : t_faults
  initial begin
    rst_in = 1'b1;
    load = 1'b0;
    bytes = 32'h00000000;
    repeat (4) @(posedge clock_in);
    #1 rst_in = 1'b0;
    t_transfer();
    t_prefix();
    t_arith();
    t_adjust();
    t_muldiv();
    t_disp();
    t_faults();
    tally_and_finish();
  end
endmodule : tb

// [sim/xsod_decoder_assertions.sv]
`timescale 1ns/1ps
module xsod_decoder_assertions (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] modrm_in,
  input wire logic [7:0] disp_lo_in,
  input wire logic ready_out,
  input wire logic done_out,
  input wire logic [6:0] min_clocks_out,
  input wire logic [6:0] max_clocks_out,
  input wire logic [1:0] seg_select_out,
  input wire logic seg_override_out,
  input wire logic [15:0] disp_out,
  input wire logic [2:0] rm_field_out,
  input wire logic invalid_operand_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic take;
  logic [6:0] since_ff;
  logic [6:0] nxt_since;
  assign take = valid_in && ready_out;
  // cycles since the last take, saturating so a long idle never wraps
  always_comb begin
    nxt_since = (since_ff == 7'h7f) ? since_ff : since_ff + 7'h01;
    if (take) nxt_since = 7'h01;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) since_ff <= 7'h00;
    else since_ff <= nxt_since;
  end
  sequence flag_busy;
    !ready_out ##1 !ready_out ##1 (ready_out && done_out);
  endsequence
  sequence ea_busy;
    (min_clocks_out == 7'd6 && !ready_out) ##1 !ready_out [*4] ##1 done_out;
  endsequence
  done_count_a: assert property (done_out |-> since_ff == min_clocks_out)
    else $error("done pulse off its count");
  flag_store_a: assert property (take && opcode_in == 8'h9e |=> flag_busy)
    else $error("flags store timing wrong");
  ea_count_a: assert property (take && opcode_in == 8'h8d |=> ea_busy)
    else $error("address load timing wrong");
  lookup_count_a: assert property (take && opcode_in == 8'hd7 |=> min_clocks_out == 7'd15)
    else $error("lookup count wrong");
  ptr_reg_bad_a: assert property (take && opcode_in[7:1] == 7'h62
    && modrm_in[7:6] == 2'h3 |=> invalid_operand_out && ready_out)
    else $error("register form pointer load accepted");
  seg_prefix_a: assert property (take && opcode_in[7:5] == 3'h1
    && opcode_in[2:0] == 3'h6 |=> seg_override_out && seg_select_out == $past(opcode_in[4:3]))
    else $error("segment prefix decode wrong");
  disp_short_a: assert property (take && opcode_in == 8'h8d && modrm_in[7:6] == 2'h1
    |=> disp_out == {{8{$past(disp_lo_in[7])}}, $past(disp_lo_in)})
    else $error("short displacement not extended");
  reg_form_a: assert property (take && opcode_in == 8'h8e && modrm_in[7:6] == 2'h3
    |=> rm_field_out == $past(modrm_in[2:0]) && min_clocks_out == 7'd2)
    else $error("register form decode wrong");
  word_mem_a: assert property (take && opcode_in == 8'h11 && modrm_in[7:6] == 2'h0
    |=> min_clocks_out == 7'd14 && max_clocks_out == 7'd16)
    else $error("word memory count wrong");
endmodule : xsod_decoder_assertions

bind xsod_decoder xsod_decoder_assertions u_check (.clock_in(clock_in), .rst_in(rst_in),
  .valid_in(valid_in), .opcode_in(opcode_in), .modrm_in(modrm_in), .disp_lo_in(disp_lo_in),
  .ready_out(ready_out), .done_out(done_out), .min_clocks_out(min_clocks_out),
  .max_clocks_out(max_clocks_out), .seg_select_out(seg_select_out),
  .seg_override_out(seg_override_out), .disp_out(disp_out), .rm_field_out(rm_field_out),
  .invalid_operand_out(invalid_operand_out));

// [sim/xsod_queue_model.sv]
`timescale 1ns/1ps
// prefetch queue: holds one instruction until the decoder takes it
module xsod_queue_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ready_in,
  input wire logic load_in,
  input wire logic [31:0] bytes_in,
  output logic valid_out,
  output logic taken_out,
  output logic [31:0] bytes_out
);
  // released bytes flip, so a stale opcode never passes for a held one
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      taken_out <= 1'b0;
      bytes_out <= 32'hffffffff;
    end else begin
      taken_out <= valid_out && ready_in;
      if (load_in) begin
        valid_out <= 1'b1;
        bytes_out <= bytes_in;
      end else if (valid_out && ready_in) begin
        valid_out <= 1'b0;
        bytes_out <= ~bytes_out;
      end
    end
  end
endmodule : xsod_queue_model
